// >>> xfer_pkg.sv
package xfer_pkg;
  localparam int DATA_W = 4;
  localparam int Z_W = 2;
  localparam int OP_W = 10;
  localparam logic [9:0] OP_LOAD_ACC_FROM_X = 10'h052;
  localparam logic [9:0] OP_LOAD_ACC_FROM_Y = 10'h01F;
  localparam logic [9:0] OP_LOAD_ACC_FROM_Z = 10'h053;
  localparam logic [9:0] OP_LOAD_B_FROM_ACC = 10'h00E;
  localparam logic [3:0] ACC_RESET = 4'h0;
  localparam logic [3:0] B_RESET = 4'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam int CYCLES_PER_OP = 1;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ACC_X,
    OP_ACC_Y,
    OP_ACC_Z,
    OP_B_ACC
  } xfer_op_t;
endpackage

// >>> xfer_decode.sv
`timescale 1ns/1ps
module xfer_decode
  import xfer_pkg::*;
(
  input wire logic [xfer_pkg::OP_W-1:0] opcode, // Instruction word
  output xfer_pkg::xfer_op_t op // Decoded transfer kind
);
  always_comb begin
    unique case (opcode)
      OP_LOAD_ACC_FROM_X: op = OP_ACC_X;
      OP_LOAD_ACC_FROM_Y: op = OP_ACC_Y;
      OP_LOAD_ACC_FROM_Z: op = OP_ACC_Z;
      OP_LOAD_B_FROM_ACC: op = OP_B_ACC;
      default: op = OP_NONE;
    endcase
  end
endmodule

// >>> register_to_accumulator_transfer.sv
`timescale 1ns/1ps
// How it works
// - X opcode copies X into accumulator
// - Y opcode copies Y into accumulator
// - Z opcode puts Z into accumulator low bits
// - Z transfer clears accumulator upper two bits
// - B opcode copies accumulator into B
module register_to_accumulator_transfer
  import xfer_pkg::*;
(
  input wire logic clk, // 200 MHz core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic instrValid, // Instruction word present this cycle
  input wire logic [xfer_pkg::OP_W-1:0] instr, // Instruction word
  input wire logic [xfer_pkg::DATA_W-1:0] regX, // Register X read port
  input wire logic [xfer_pkg::DATA_W-1:0] regY, // Register Y read port
  input wire logic [xfer_pkg::Z_W-1:0] regZ, // Register Z read port
  input wire logic carryIn, // Carry flag from the core
  output logic [xfer_pkg::DATA_W-1:0] acc_ff, // Accumulator A
  output logic [xfer_pkg::DATA_W-1:0] regB_ff, // Register B
  output logic carry_flag_ff, // Carry flag passed through unchanged
  output logic skipNext_ff, // Skip request, never raised here
  output logic accWrite_ff, // Pulse: accumulator was written
  output logic bWrite_ff // Pulse: register B was written
);
  // Decoded transfer kind, and the same kind gated by the valid strobe
  xfer_op_t op;
  xfer_op_t opQual;

  // One flag per transfer; the decoder keeps them mutually exclusive
  logic isLoadX;
  logic isLoadY;
  logic isLoadZ;
  logic isLoadB;
  logic isAccDest;

  // Z widened to the accumulator, and the source chosen for it
  logic [DATA_W-1:0] zWide;
  logic [DATA_W-1:0] accSrc;

  // Next values, one per register
  logic [DATA_W-1:0] nxt_acc;
  logic [DATA_W-1:0] nxt_regB;
  logic nxt_carry_flag;
  logic nxt_skipNext;
  logic nxt_accWrite;
  logic nxt_bWrite;

  xfer_decode u_dec (
    .opcode(instr),
    .op(op)
  );

  // Idle cycles and unknown words both fall to the no-transfer kind
  always_comb begin
    if (instrValid) begin
      opQual = op;
    end else begin
      opQual = OP_NONE;
    end
  end

  // The three-bit kind has spare codes, hence the default
  always_comb begin
    isLoadX = 1'b0;
    isLoadY = 1'b0;
    isLoadZ = 1'b0;
    isLoadB = 1'b0;
    unique case (opQual)
      OP_ACC_X: begin
        isLoadX = 1'b1;
      end
      OP_ACC_Y: begin
        isLoadY = 1'b1;
      end
      OP_ACC_Z: begin
        isLoadZ = 1'b1;
      end
      OP_B_ACC: begin
        isLoadB = 1'b1;
      end
      OP_NONE: begin
        isLoadB = 1'b0;
      end
      default: begin
        isLoadB = 1'b0;
      end
    endcase
  end

  assign isAccDest = isLoadX || isLoadY || isLoadZ;

  // Per accumulator bit: widen Z, then pick the source
  for (genvar i = 0; i < DATA_W; i++) begin : g_accBit
    logic srcBit;
    if (i < Z_W) begin : g_low
      assign zWide[i] = regZ[i];
    end else begin : g_high
      assign zWide[i] = 1'b0;
    end
    // Priority order costs nothing here, the flags never overlap
    always_comb begin
      if (isLoadX) begin
        srcBit = regX[i];
      end else if (isLoadY) begin
        srcBit = regY[i];
      end else begin
        srcBit = zWide[i];
      end
    end
    assign accSrc[i] = srcBit;
  end

  // Only the three accumulator transfers may change the accumulator
  always_comb begin
    nxt_acc = acc_ff;
    unique case (opQual)
      OP_ACC_X: begin
        nxt_acc = accSrc;
      end
      OP_ACC_Y: begin
        nxt_acc = accSrc;
      end
      OP_ACC_Z: begin
        nxt_acc = accSrc;
      end
      OP_B_ACC: begin
        nxt_acc = acc_ff;
      end
      OP_NONE: begin
        nxt_acc = acc_ff;
      end
      default: begin
        nxt_acc = acc_ff;
      end
    endcase
  end

  // B reads the accumulator register, not nxt_acc, so it takes the old value
  always_comb begin
    nxt_regB = regB_ff;
    unique case (opQual)
      OP_B_ACC: begin
        nxt_regB = acc_ff;
      end
      OP_ACC_X: begin
        nxt_regB = regB_ff;
      end
      OP_ACC_Y: begin
        nxt_regB = regB_ff;
      end
      OP_ACC_Z: begin
        nxt_regB = regB_ff;
      end
      OP_NONE: begin
        nxt_regB = regB_ff;
      end
      default: begin
        nxt_regB = regB_ff;
      end
    endcase
  end

  // Carry is only mirrored from the core; no transfer may alter it
  always_comb begin
    nxt_carry_flag = carryIn;
    nxt_skipNext = FLAG_RESET;
  end

  // Write pulses let the core see which destination changed
  always_comb begin
    nxt_accWrite = isAccDest;
    nxt_bWrite = isLoadB;
  end

  // Accumulator
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_ff <= ACC_RESET;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // Register B
  always_ff @(posedge clk) begin
    if (rst) begin
      regB_ff <= B_RESET;
    end else begin
      regB_ff <= nxt_regB;
    end
  end

  // Carry mirror, one cycle behind the core
  always_ff @(posedge clk) begin
    if (rst) begin
      carry_flag_ff <= FLAG_RESET;
    end else begin
      carry_flag_ff <= nxt_carry_flag;
    end
  end

  // Skip request stays low: none of these transfers skips
  always_ff @(posedge clk) begin
    if (rst) begin
      skipNext_ff <= FLAG_RESET;
    end else begin
      skipNext_ff <= nxt_skipNext;
    end
  end

  // Accumulator write pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      accWrite_ff <= FLAG_RESET;
    end else begin
      accWrite_ff <= nxt_accWrite;
    end
  end

  // Register B write pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      bWrite_ff <= FLAG_RESET;
    end else begin
      bWrite_ff <= nxt_bWrite;
    end
  end
endmodule

// >>> xfer_asserts.sv
`timescale 1ns/1ps
module xfer_asserts (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic instrValid, // Valid
  input wire logic [9:0] instr, // Opcode
  input wire logic [3:0] regX, // X
  input wire logic [3:0] regY, // Y
  input wire logic [1:0] regZ, // Z
  input wire logic carryIn, // Carry
  input wire logic [3:0] acc_ff, // Acc
  input wire logic [3:0] regB_ff, // B
  input wire logic carry_flag_ff, // Carry
  input wire logic skipNext_ff, // Skip
  input wire logic accWrite_ff, // Acc write pulse
  input wire logic bWrite_ff // B write pulse
);
  logic accOp;
  logic bOp;
  assign accOp = instrValid && (instr == 10'h052 || instr == 10'h01F || instr == 10'h053);
  assign bOp = instrValid && instr == 10'h00E;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_op(logic [9:0] c); instrValid && instr == c; endsequence
  a_acc_pulse: assert property (accOp |=> accWrite_ff) else $error("acc pulse");
  a_acc_quiet: assert property (!accOp |=> !accWrite_ff) else $error("acc quiet");
  a_b_pulse: assert property (s_op(10'h00E) |=> bWrite_ff) else $error("B pulse");
  a_b_quiet: assert property (!bOp |=> !bWrite_ff) else $error("B quiet");
  a_acc_hold: assert property (!accOp |=> acc_ff == $past(acc_ff)) else $error("acc");
  a_b_hold: assert property (!bOp |=> regB_ff == $past(regB_ff)) else $error("B hold");
  a_x_acc: assert property (s_op(10'h052) |=> acc_ff == $past(regX)) else $error("X");
  a_y_acc: assert property (s_op(10'h01F) |=> acc_ff == $past(regY)) else $error("Y");
  a_z_low: assert property (s_op(10'h053) |=> acc_ff[1:0] == $past(regZ)) else $error("Z");
  a_z_high: assert property (s_op(10'h053) |=> acc_ff[3:2] == 2'h0) else $error("Z hi");
  a_acc_b: assert property (s_op(10'h00E) |=> regB_ff == $past(acc_ff)) else $error("B");
  // Guarded by past reset, since flags are cleared during reset
  a_flag_keep: assert property (!$past(rst) |-> !skipNext_ff && carry_flag_ff == $past(carryIn))
    else $error("flags");
endmodule
bind register_to_accumulator_transfer xfer_asserts chk (.clk, .rst, .instrValid, .instr, .regX,
  .regY, .regZ, .carryIn, .acc_ff, .regB_ff, .carry_flag_ff, .skipNext_ff, .accWrite_ff,
  .bWrite_ff);

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst = 1, instrValid = 0, carryIn = 0, eC = 0, carry_flag_ff, skipNext_ff;
  logic eAW = 0, eBW = 0, accWrite_ff, bWrite_ff;
  logic [9:0] instr = 10'h000;
  logic [9:0] op [4] = '{10'h052, 10'h01F, 10'h053, 10'h00E};
  logic [3:0] regX = 4'h0, regY = 4'h0, eA = 4'h0, eB = 4'h0, acc_ff, regB_ff;
  logic [1:0] regZ = 2'h0;
  int fails = 0, check_count = 0;
  register_to_accumulator_transfer DUT (.clk, .rst, .instrValid, .instr, .regX, .regY, .regZ,
    .carryIn, .acc_ff, .regB_ff, .carry_flag_ff, .skipNext_ff, .accWrite_ff, .bWrite_ff);
  initial forever #2.5 clk = ~clk;
  function logic [3:0] accExp(input logic [3:0] a);
    if (!instrValid) return a;
    case (instr)
      10'h052: return regX;
      10'h01F: return regY;
      10'h053: return {2'h0, regZ};
      default: return a;
    endcase
  endfunction
  task check(input logic [3:0] seen, input logic [3:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("mismatch %0t: %h vs %h", $time, seen, want);
    end
  endtask
  task results;
    $display("fails %0d check_count %0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(78));
    repeat (16) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 600; i++) begin
      @(negedge clk);
      eAW = instrValid && (instr == 10'h052 || instr == 10'h01F || instr == 10'h053);
      eBW = instrValid && instr == 10'h00E;
      // B takes the old accumulator, so it is modelled first
      if (eBW) eB = eA;
      eA = accExp(eA);
      eC = carryIn;
      if (rst) {eA, eB, eC, eAW, eBW} = 11'h000;
      check(acc_ff, eA);
      check(regB_ff, eB);
      check({skipNext_ff, carry_flag_ff, accWrite_ff, bWrite_ff}, {1'b0, eC, eAW, eBW});
      {instrValid, carryIn, regZ, regY, regX} = 12'($urandom);
      instr = ($urandom % 5) ? op[$urandom % 4] : 10'($urandom);
      // Mid-run reset for two edges
      rst = (i == 300 || i == 301);
    end
    results();
  end
endmodule
